// >>> hw/ecm_host.sv
// host controller that drives the echo canceller through its system bus pins
// assumes pin inputs synchronous to clock; the device paces every exchange
// Summary of operation
// - all mailbox data over 8-bit bus
// - chip select asserted only within exchange
// - host bus driver off outside exchanges
// - three estimates in, three errors out
// - symbol byte: real high, imaginary low
// - exactly three exchanges per baud
// - read low, high; write errors, symbol once
// - host never stalls exchange beyond need
// - reset held low at least 640 ns
// - delay sent next, below 3000
`timescale 1ns/1ps
`default_nettype none
module ecm_host #(
    parameter int RESET_CYCLES  = ecm_pkg::RESET_CYCLES,
    parameter int STROBE_CYCLES = ecm_pkg::STROBE_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset,
    // software port
    input  wire logic [3:0]  address,
    input  wire logic [15:0] writeData,
    input  wire logic        writeStrobe,
    input  wire logic        readStrobe,
    output logic [15:0]      readData,
    // device pins
    output logic             devResetN,
    output logic             chipSelectN,
    output logic             registerSelect,
    output logic             dataStrobeN,
    output logic             readWriteN,
    input  wire logic [7:0]  busIn,
    output logic [7:0]       busOut,
    output logic             busOe,
    input  wire logic        interruptN,
    input  wire logic        transferAckN
);
    // refuse reset counts that the 16-bit cycle counter cannot serve, and strobe counts over 255
    if (RESET_CYCLES < 1 || RESET_CYCLES > 65535) begin : g_bad_reset
        $error("bad reset count");
    end
    if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255) begin : g_bad_strobe
        $error("bad strobe count");
    end

    ecm_pkg::ecm_state_t state_reg;
    ecm_pkg::ecm_exch_t  exch_reg;
    logic [15:0] count_reg;
    logic [1:0]  byteIdx_reg;    // byte within exchange
    logic        writePhase_reg; // 0 reads three bytes, 1 writes three
    logic [1:0]  sample_reg;     // exchange within baud
    logic [23:0] inbound_reg;
    logic [23:0] outbound_reg;
    logic [15:0] delay_reg;
    logic        farEn_reg;
    logic        nearReq_reg;
    logic        initReq_reg;
    logic        configured_reg;
    logic        nearDone_reg;
    logic        badDelay_reg;
    logic [15:0] error_reg [3];
    logic [7:0]  symbol_reg;
    logic [15:0] estim_reg [3];

    // byte n of a 24-bit word, low byte first
    function automatic logic [7:0] byteOf(input logic [23:0] w, input logic [1:0] n);
        case (n)
            2'd0:    byteOf = w[7:0];
            2'd1:    byteOf = w[15:8];
            default: byteOf = w[23:16];
        endcase
    endfunction : byteOf

    // software writes; a start request clears only after it is taken
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            delay_reg   <= 16'h0000;
            farEn_reg   <= 1'b0;
            nearReq_reg <= 1'b0;
            initReq_reg <= 1'b0;
            symbol_reg  <= 8'h00;
            for (int i = 0; i < 3; i++) error_reg[i] <= 16'h0000;
        end else begin
            if (state_reg == ecm_pkg::ST_IDLE && initReq_reg)
                initReq_reg <= 1'b0;
            if (exch_reg == ecm_pkg::EX_NEAR && state_reg == ecm_pkg::ST_NEXT)
                nearReq_reg <= 1'b0;
            if (writeStrobe) begin
                case (address)
                    ecm_pkg::CTRL_OFF: begin
                        // set wins over hardware clear
                        if (writeData[ecm_pkg::CTRL_INIT_BIT]) initReq_reg <= 1'b1;
                        if (writeData[ecm_pkg::CTRL_NEAR_BIT]) nearReq_reg <= 1'b1;
                        farEn_reg <= writeData[ecm_pkg::CTRL_FAR_BIT];
                    end
                    ecm_pkg::DELAY_OFF:  delay_reg    <= writeData;
                    ecm_pkg::ERROR0_OFF: error_reg[0] <= writeData;
                    ecm_pkg::ERROR1_OFF: error_reg[1] <= writeData;
                    ecm_pkg::ERROR2_OFF: error_reg[2] <= writeData;
                    ecm_pkg::SYMBOL_OFF: symbol_reg   <= writeData[7:0];
                    default: ;
                endcase
            end
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            readData <= 16'h0000;
        end else if (readStrobe) begin
            case (address)
                ecm_pkg::CTRL_OFF:   readData <= {13'h0000, nearReq_reg, farEn_reg, initReq_reg};
                ecm_pkg::DELAY_OFF:  readData <= delay_reg;
                ecm_pkg::ERROR0_OFF: readData <= error_reg[0];
                ecm_pkg::ERROR1_OFF: readData <= error_reg[1];
                ecm_pkg::ERROR2_OFF: readData <= error_reg[2];
                ecm_pkg::SYMBOL_OFF: readData <= {8'h00, symbol_reg};
                ecm_pkg::ESTIM0_OFF: readData <= estim_reg[0];
                ecm_pkg::ESTIM1_OFF: readData <= estim_reg[1];
                ecm_pkg::ESTIM2_OFF: readData <= estim_reg[2];
                ecm_pkg::STATUS_OFF: readData <= {12'h000, badDelay_reg, nearDone_reg,
                                                  configured_reg, state_reg != ecm_pkg::ST_IDLE};
                default:             readData <= 16'h0000;
            endcase
        end else begin
            readData <= 16'h0000;
        end
    end

    // outbound word for the current exchange
    always_comb begin
        case (exch_reg)
            ecm_pkg::EX_CFG:   outbound_reg = ecm_pkg::CFG_START_PAT;
            ecm_pkg::EX_DELAY: outbound_reg = {7'h00, farEn_reg, delay_reg};
            ecm_pkg::EX_NEAR:  outbound_reg = ecm_pkg::NEAR_EN_PAT;
            default:           outbound_reg = {(sample_reg == 2'd0) ? symbol_reg : 8'h00,
                                               error_reg[sample_reg]};
        endcase
    end

    // main sequencer: reset pulse, then exchanges paced by the interrupt
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg      <= ecm_pkg::ST_RESET;
            exch_reg       <= ecm_pkg::EX_CFG;
            count_reg      <= 16'h0000;
            byteIdx_reg    <= 2'd0;
            writePhase_reg <= 1'b0;
            sample_reg     <= 2'd0;
            inbound_reg    <= 24'h00_0000;
            configured_reg <= 1'b0;
            nearDone_reg   <= 1'b0;
            badDelay_reg   <= 1'b0;
            for (int i = 0; i < 3; i++) estim_reg[i] <= 16'h0000;
        end else begin
            case (state_reg)
                ecm_pkg::ST_RESET: begin
                    if (count_reg == 16'(RESET_CYCLES - 1)) begin
                        count_reg <= 16'h0000;
                        state_reg <= ecm_pkg::ST_IDLE;
                    end else begin
                        count_reg <= count_reg + 16'h0001;
                    end
                end
                ecm_pkg::ST_IDLE: begin
                    byteIdx_reg    <= 2'd0;
                    writePhase_reg <= 1'b0;
                    if (initReq_reg) begin
                        // refuse delay at or over limit
                        badDelay_reg   <= delay_reg >= ecm_pkg::DELAY_LIMIT;
                        configured_reg <= 1'b0;
                        exch_reg       <= ecm_pkg::EX_CFG;
                        state_reg      <= (delay_reg >= ecm_pkg::DELAY_LIMIT) ?
                                          ecm_pkg::ST_IDLE : ecm_pkg::ST_WAITIRQ;
                    end else if (configured_reg) begin
                        exch_reg  <= nearReq_reg ? ecm_pkg::EX_NEAR : ecm_pkg::EX_DATA;
                        state_reg <= ecm_pkg::ST_WAITIRQ;
                    end
                end
                ecm_pkg::ST_WAITIRQ: begin
                    // a near request made while already waiting still takes the next exchange,
                    // otherwise it would slip a whole sample behind a data exchange
                    if (exch_reg == ecm_pkg::EX_DATA && nearReq_reg) exch_reg <= ecm_pkg::EX_NEAR;
                    if (!interruptN) state_reg <= ecm_pkg::ST_SETUP;
                end
                ecm_pkg::ST_SETUP: begin
                    count_reg <= 16'h0000;
                    state_reg <= ecm_pkg::ST_STROBE;
                end
                ecm_pkg::ST_STROBE: begin
                    if (count_reg == 16'(STROBE_CYCLES - 1)) state_reg <= ecm_pkg::ST_WAITACK;
                    else count_reg <= count_reg + 16'h0001;
                end
                ecm_pkg::ST_WAITACK: begin
                    if (!transferAckN) begin
                        if (!writePhase_reg)
                            inbound_reg <= {busIn, inbound_reg[23:8]};
                        state_reg <= ecm_pkg::ST_RELEASE;
                    end
                end
                ecm_pkg::ST_RELEASE: begin
                    if (transferAckN) state_reg <= ecm_pkg::ST_NEXT;
                end
                ecm_pkg::ST_NEXT: begin
                    if (byteIdx_reg != 2'd2) begin
                        byteIdx_reg <= byteIdx_reg + 2'd1;
                        state_reg   <= ecm_pkg::ST_SETUP;
                    end else if (!writePhase_reg) begin
                        byteIdx_reg    <= 2'd0;
                        writePhase_reg <= 1'b1;
                        if (exch_reg == ecm_pkg::EX_DATA) estim_reg[sample_reg] <= inbound_reg[15:0];
                        state_reg <= ecm_pkg::ST_SETUP;
                    end else begin
                        state_reg <= ecm_pkg::ST_WAITEND;
                    end
                end
                // device ends the exchange by lifting its interrupt
                ecm_pkg::ST_WAITEND: begin
                    if (interruptN) begin
                        byteIdx_reg    <= 2'd0;
                        writePhase_reg <= 1'b0;
                        case (exch_reg)
                            ecm_pkg::EX_CFG: begin
                                exch_reg  <= ecm_pkg::EX_DELAY;
                                state_reg <= ecm_pkg::ST_WAITIRQ;
                            end
                            ecm_pkg::EX_DELAY: begin
                                configured_reg <= 1'b1;
                                state_reg      <= ecm_pkg::ST_IDLE;
                            end
                            ecm_pkg::EX_NEAR: begin
                                nearDone_reg <= 1'b1;
                                state_reg    <= ecm_pkg::ST_IDLE;
                            end
                            default: begin
                                sample_reg <= (sample_reg == 2'(ecm_pkg::EXCH_PER_BAUD - 1)) ?
                                              2'd0 : sample_reg + 2'd1;
                                state_reg  <= ecm_pkg::ST_IDLE;
                            end
                        endcase
                    end
                end
                default: state_reg <= ecm_pkg::ST_IDLE;
            endcase
        end
    end

    // pin drive; data only while chip select is low in a write (setup, strobe and acknowledge wait)
    // bus released otherwise
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            devResetN      <= 1'b0;
            chipSelectN    <= 1'b1;
            registerSelect <= 1'b0;
            dataStrobeN    <= 1'b1;
            readWriteN     <= 1'b1;
            busOut         <= 8'h00;
            busOe          <= 1'b0;
        end else begin
            devResetN      <= state_reg != ecm_pkg::ST_RESET;
            chipSelectN    <= !(state_reg inside {ecm_pkg::ST_SETUP, ecm_pkg::ST_STROBE,
                                                  ecm_pkg::ST_WAITACK});
            registerSelect <= ecm_pkg::RS_DATA;
            dataStrobeN    <= !(state_reg inside {ecm_pkg::ST_STROBE, ecm_pkg::ST_WAITACK});
            readWriteN     <= !writePhase_reg;
            busOut         <= byteOf(outbound_reg, byteIdx_reg);
            busOe          <= writePhase_reg && (state_reg inside {ecm_pkg::ST_SETUP,
                              ecm_pkg::ST_STROBE, ecm_pkg::ST_WAITACK});
        end
    end
endmodule : ecm_host
`default_nettype wire

// >>> hw/ecm_pkg.sv
// package for the echo canceller mailbox host controller
// assumes a 125 MHz clock and the device reached over its 8-bit system bus
package ecm_pkg;
    // host-side register offsets
    localparam logic [3:0] CTRL_OFF     = 4'h0;  // bit0 start init, bit1 far enable, bit2 near enable
    localparam logic [3:0] DELAY_OFF    = 4'h1;  // far-end round trip delay in bauds
    localparam logic [3:0] ERROR0_OFF   = 4'h2;  // cancellation errors, one per sample
    localparam logic [3:0] ERROR1_OFF   = 4'h3;
    localparam logic [3:0] ERROR2_OFF   = 4'h4;
    localparam logic [3:0] SYMBOL_OFF   = 4'h5;  // symbol: [7:4] real, [3:0] imag
    localparam logic [3:0] ESTIM0_OFF   = 4'h6;  // echo estimates read back
    localparam logic [3:0] ESTIM1_OFF   = 4'h7;
    localparam logic [3:0] ESTIM2_OFF   = 4'h8;
    localparam logic [3:0] STATUS_OFF   = 4'h9;
    // control and status bit positions
    localparam int CTRL_INIT_BIT   = 0;
    localparam int CTRL_FAR_BIT    = 1;
    localparam int CTRL_NEAR_BIT   = 2;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_CONFIG_BIT = 1;
    localparam int STAT_NEAR_BIT   = 2;
    localparam int STAT_BAD_BIT    = 3;
    // mailbox register select values on the device pins
    localparam logic RS_DATA = 1'b0;
    // fixed command patterns, byte 0 first
    localparam logic [23:0] CFG_START_PAT = 24'h00_0AAA;
    localparam logic [23:0] NEAR_EN_PAT   = 24'h01_AAAA;
    localparam logic [15:0] DELAY_LIMIT   = 16'h0BB8;   // 3000 bauds
    localparam int EXCH_PER_BAUD = 3;
    // timing
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int RESET_MIN_NS   = 640;
    localparam int RESET_CYCLES   = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_MIN_NS  = 60;
    localparam int STROBE_CYCLES  = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // controller states
    typedef enum logic [3:0] {
        ST_RESET   = 4'b0000,
        ST_IDLE    = 4'b0001,
        ST_WAITIRQ = 4'b0010,
        ST_SETUP   = 4'b0011,
        ST_STROBE  = 4'b0100,
        ST_WAITACK = 4'b0101,
        ST_RELEASE = 4'b0110,
        ST_NEXT    = 4'b0111,
        ST_WAITEND = 4'b1000
    } ecm_state_t;
    // what the current exchange carries
    typedef enum logic [1:0] {
        EX_CFG   = 2'b00,
        EX_DELAY = 2'b01,
        EX_NEAR  = 2'b10,
        EX_DATA  = 2'b11
    } ecm_exch_t;
endpackage : ecm_pkg

// >>> testbench/ecm_host_properties.sv
// assertions on the host controller pins and software port
// assumes a bind onto ecm_host and one clock domain
`timescale 1ns/1ps
`default_nettype none
module ecm_host_properties #(
    parameter int RESET_CYCLES  = 80,
    parameter int STROBE_CYCLES = 8
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        readStrobe,
    input wire logic [15:0] readData,
    input wire logic        devResetN,
    input wire logic        chipSelectN,
    input wire logic        dataStrobeN,
    input wire logic        readWriteN,
    input wire logic        busOe,
    input wire logic        interruptN,
    input wire logic        transferAckN
);
    int rstCnt_reg;
    int dsCnt_reg;
    // cycles the device reset and the strobe have been low
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rstCnt_reg <= 0;
            dsCnt_reg  <= 0;
        end else begin
            rstCnt_reg <= devResetN ? rstCnt_reg : rstCnt_reg + 1;
            dsCnt_reg  <= dataStrobeN ? 0 : dsCnt_reg + 1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_ds_start; $fell(dataStrobeN); endsequence
    sequence s_ds_end; $rose(dataStrobeN); endsequence
    sequence s_waiting; !dataStrobeN && transferAckN; endsequence
    chk_reset_len: assert property (
        $rose(devResetN) |-> rstCnt_reg >= RESET_CYCLES - 1 && rstCnt_reg <= RESET_CYCLES + 1)
        else $error("device reset length wrong");
    chk_idle_reset: assert property (
        !devResetN |-> chipSelectN && dataStrobeN) else $error("access while device in reset");
    chk_needs_irq: assert property (
        s_ds_start |-> !$past(interruptN)) else $error("strobe without device request");
    chk_hold_ack: assert property (
        s_waiting |=> !dataStrobeN) else $error("strobe dropped before acknowledge");
    chk_ack_free: assert property (
        s_ds_start |-> $past(transferAckN)) else $error("strobe while acknowledge still low");
    chk_strobe_len: assert property (
        s_ds_end |-> dsCnt_reg >= STROBE_CYCLES) else $error("strobe too short");
    chk_cs_frames: assert property (
        !dataStrobeN |-> !chipSelectN) else $error("strobe without chip select");
    chk_dir_stable: assert property (
        !dataStrobeN ##1 !dataStrobeN |-> $stable(readWriteN) && $stable(busOe))
        else $error("direction changed inside strobe");
    chk_oe_write: assert property (
        busOe |-> !readWriteN) else $error("bus driven outside write");
    chk_read_quiet: assert property (
        !$past(readStrobe) |-> readData == 16'h0000) else $error("read data outside its cycle");
endmodule : ecm_host_properties
`default_nettype wire

// >>> testbench/ecm_dev_model.sv
// mailbox side of the echo canceller device
// assumes host pins of ecm_host; exchanges are started by the bench
`timescale 1ns/1ps
`default_nettype none
module ecm_dev_model (
    input  wire logic       clock,
    input  wire logic       devResetN,
    input  wire logic       chipSelectN,
    input  wire logic       dataStrobeN,
    input  wire logic       readWriteN,
    input  wire logic [7:0] busOut,
    input  wire logic       busOe,
    output logic [7:0]      busIn,
    output logic            interruptN,
    output logic            transferAckN
);
    int ackDelay = 0;  // slow device when above zero
    int errs     = 0;  // order and drive faults seen
    // idle again whenever held in reset
    always @(negedge devResetN) begin
        interruptN   <= 1'b1;
        transferAckN <= 1'b1;
    end
    initial begin
        busIn        = 8'h5a;
        interruptN   = 1'b1;
        transferAckN = 1'b1;
    end
    // one exchange, 3 reads then 3 writes
    task automatic exchange(input logic [23:0] outv, output logic [23:0] inv);
        int i;
        inv = 24'h00_0000;
        @(posedge clock);
        interruptN <= 1'b0;
        for (i = 0; i < 6; i++) begin
            @(posedge clock iff (!dataStrobeN && !chipSelectN));
            repeat (ackDelay) @(posedge clock);
            if (readWriteN !== (i < 3)) errs++;
            if (i < 3) busIn <= outv[8*i +: 8];
            else if (busOe === 1'b1) inv[8*(i-3) +: 8] = busOut;
            else errs++;
            transferAckN <= 1'b0;
            @(posedge clock iff dataStrobeN);
            // released bus never keeps the old byte
            busIn        <= ~busIn;
            transferAckN <= 1'b1;
        end
        interruptN <= 1'b1;
        // keep the request off until the host has seen the exchange end
        repeat (4) @(posedge clock);
    endtask : exchange
endmodule : ecm_dev_model
`default_nettype wire

// >>> testbench/tb_ecm_host.sv
// self-checking bench for the echo canceller host controller
// assumes ecm_pkg, ecm_host, the device model and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_ecm_host;
    localparam int RST_CYC = 4;  // shortened to keep the run brief
    logic        clock, reset, writeStrobe, readStrobe;
    logic [3:0]  address;
    logic [15:0] writeData, readData;
    logic        devResetN, chipSelectN, registerSelect, dataStrobeN, readWriteN, busOe, interruptN, transferAckN;
    logic [7:0]  busIn, busOut;
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    ecm_host #(.RESET_CYCLES(RST_CYC), .STROBE_CYCLES(2)) i_ecm_host (.clock, .reset, .address, .writeData,
        .writeStrobe, .readStrobe, .readData, .devResetN, .chipSelectN, .registerSelect, .dataStrobeN,
        .readWriteN, .busIn, .busOut, .busOe, .interruptN, .transferAckN);
    ecm_dev_model i_ecm_dev_model (.clock, .devResetN, .chipSelectN, .dataStrobeN, .readWriteN, .busOut,
        .busOe, .busIn, .interruptN, .transferAckN);
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        address     <= a;
        writeData   <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        address    <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 d = readData;
    endtask : rd
    // bounded poll of one status bit
    task automatic poll(input int b, output logic [15:0] d);
        for (int n = 0; n < 60; n++) begin
            rd(ecm_pkg::STATUS_OFF, d);
            if (d[b] === 1'b1) break;
        end
    endtask : poll
    task automatic t_reset();
        logic [15:0] d;
        int n = 0;
        while (devResetN !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        check_val(24'(n >= RST_CYC - 1 && n <= RST_CYC + 2), 24'h00_0001);
        rd(ecm_pkg::STATUS_OFF, d);
        check_val({8'h00, d}, 24'h00_0000);
        rd(4'hF, d);
        check_val({8'h00, d}, 24'h00_0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_bad_delay();
        logic [15:0] d;
        wr(ecm_pkg::DELAY_OFF, 16'h0BB8);
        wr(ecm_pkg::CTRL_OFF, 16'h0001);
        poll(ecm_pkg::STAT_BAD_BIT, d);
        check_val({23'h0, d[ecm_pkg::STAT_BAD_BIT]}, 24'h00_0001);
        check_val({23'h0, chipSelectN}, 24'h00_0001);
        $display("test bad delay done");
    endtask : t_bad_delay
    task automatic t_init();
        logic [23:0] inb;
        logic [15:0] d;
        wr(ecm_pkg::DELAY_OFF, 16'h0BB7);
        wr(ecm_pkg::CTRL_OFF, 16'h0003);
        i_ecm_dev_model.exchange(24'h00_0000, inb);
        check_val(inb, ecm_pkg::CFG_START_PAT);
        check_val({23'h0, registerSelect}, {23'h0, ecm_pkg::RS_DATA});
        i_ecm_dev_model.exchange(24'h00_0000, inb);
        check_val(inb, 24'h01_0BB7);
        poll(ecm_pkg::STAT_CONFIG_BIT, d);
        check_val({23'h0, d[ecm_pkg::STAT_CONFIG_BIT]}, 24'h00_0001);
        $display("test init done");
    endtask : t_init
    task automatic t_data();
        logic [23:0] inb;
        logic [15:0] d;
        logic [15:0] err [3] = '{16'h1234, 16'h8001, 16'hFFFE};
        logic [23:0] est [3] = '{24'h77_C3E1, 24'h01_00FF, 24'hEE_8000};
        for (int s = 0; s < 3; s++) wr(ecm_pkg::ERROR0_OFF + 4'(s), err[s]);
        wr(ecm_pkg::SYMBOL_OFF, 16'h003D);
        for (int s = 0; s < 3; s++) begin
            i_ecm_dev_model.ackDelay = (s == 1) ? 3 : 0;
            i_ecm_dev_model.exchange(est[s], inb);
            check_val(inb, {(s == 0) ? 8'h3D : 8'h00, err[s]});
        end
        for (int s = 0; s < 3; s++) begin
            rd(ecm_pkg::ESTIM0_OFF + 4'(s), d);
            check_val({8'h00, d}, {8'h00, est[s][15:0]});
        end
        $display("test data done");
    endtask : t_data
    task automatic t_near();
        logic [23:0] inb;
        logic [15:0] d;
        wr(ecm_pkg::CTRL_OFF, 16'h0004);
        i_ecm_dev_model.exchange(24'h12_3456, inb);
        check_val(inb, ecm_pkg::NEAR_EN_PAT);
        poll(ecm_pkg::STAT_NEAR_BIT, d);
        check_val({23'h0, d[ecm_pkg::STAT_NEAR_BIT]}, 24'h00_0001);
        $display("test near done");
    endtask : t_near
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // hang guard, far above the expected several hundred cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        reset       = 1'b1;
        address     = 4'h0;
        writeData   = 16'h0000;
        writeStrobe = 1'b0;
        readStrobe  = 1'b0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_bad_delay();
        t_init();
        t_data();
        t_near();
        check_val(24'(i_ecm_dev_model.errs), 24'h00_0000);
        final_report();
    end
endmodule : tb_ecm_host
bind ecm_host ecm_host_properties #(.RESET_CYCLES(RESET_CYCLES), .STROBE_CYCLES(STROBE_CYCLES)) i_chk (
    .clock, .reset, .readStrobe, .readData, .devResetN, .chipSelectN, .dataStrobeN, .readWriteN, .busOe,
    .interruptN, .transferAckN);
`default_nettype wire
